// [rtl/idtc_params.svh]
/*
 * Address map, field positions and fixed constants of the IQ down
 * converter, trigger and capture block. Assumes a byte-addressed register
 * port with 8-bit addresses and 32-bit data.
 */
`ifndef IDTC_PARAMS_SVH
`define IDTC_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define IDTC_A_CTRL   8'h00
`define IDTC_A_TRIG   8'h04
`define IDTC_A_DEC    8'h08
`define IDTC_A_MODE   8'h0C
`define IDTC_A_SHIFT  8'h10
`define IDTC_A_WIN    8'h14
`define IDTC_A_THR    8'h18
`define IDTC_A_PER    8'h1C
`define IDTC_A_PKTS   8'h20
`define IDTC_A_SPP    8'h24
`define IDTC_A_SWORD  8'h28
`define IDTC_A_STAT   8'h2C
`define IDTC_A_BINW   8'h30
`define IDTC_A_SWEEP  8'h34
// ----------------------------------------
// fields
// ----------------------------------------
`define IDTC_C_BLK    0
`define IDTC_C_STR    1
`define IDTC_C_STOP   2
`define IDTC_C_READ   3
`define IDTC_M_CIC    2
`define IDTC_W_STOP   16
// ----------------------------------------
// constants
// ----------------------------------------
`define IDTC_DEC_MAX  4'hA
`define IDTC_SH_IF_INC 32'h47AE147B
`define IDTC_BINW_BASE 32'h001DCD65
`define IDTC_MEM_AW   12
`define IDTC_MEM_N    13'h1000
`endif

// [rtl/idtc_pkg.sv]
/*
 * Types of the IQ down converter, trigger and capture block.
 * Assumes idtc_params.svh is on the include path.
 */
package idtc_pkg;
	typedef struct packed {
		logic signed [15:0] i;
		logic signed [15:0] q;
	} idtc_iq_s;
	typedef enum logic [5:0] {
		TRIG_NONE     = 6'h01,
		TRIG_LEVEL    = 6'h02,
		TRIG_PERIODIC = 6'h04,
		TRIG_PPS      = 6'h08,
		TRIG_PULSE    = 6'h10,
		TRIG_WORD     = 6'h20
	} idtc_trig_e;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARM  = 5'h02,
		ST_CAP  = 5'h04,
		ST_HOLD = 5'h08,
		ST_READ = 5'h10
	} idtc_state_e;
endpackage : idtc_pkg

// [rtl/idtc_top.sv]
/*
 * Down converter (oscillator, mixer, FIR or CIC+FIR decimator), trigger
 * unit and capture controller. Assumes an external 1024-point FFT core
 * fed from fft_in_* that returns bin magnitudes on fft_bin_*.
 */
// Contract
// [RQ1] oscillator sinusoid mixed with IQ input
// [RQ2] FIR or CIC plus FIR, own decimator
// [RQ3] real-only paths yield complex output
// [RQ4] only one trigger type at once
// [RQ5] FFT of 1024 samples drives level
// [RQ6] bin width follows decimation rate
// [RQ7] window of bins, single threshold
// [RQ8] any bin above threshold triggers
// [RQ9] samples after trigger go to memory
// [RQ10] periodic trigger repeats captures
// [RQ11] pin triggers start capture
// [RQ12] trace uses root settings only
// [RQ13] block capture contiguous, held until read
// [RQ14] stream best effort, drops when full
// [RQ15] none runs free, else wait
// [RQ16] block length is packets times spp; code clamps it to 4096
// [RQ17] read command sends stored block
// [RQ18] stream start runs, stop halts
// [RQ19] trace pauses then resumes sweep
// [RQ20] decimation is two to level, max ten
// [RQ21] superhet with decimation adds 35MHz shift
// [RQ22] one compare per frame, latched trigger
// [RQ23] phase accumulator feeds sine lookup
`timescale 1ns/1ps
`include "idtc_params.svh"
module idtc_top (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               srst,
	// register port
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [31:0]        reg_rdata,
	// digitized samples
	input  wire logic               adc_valid,
	input  wire idtc_pkg::idtc_iq_s adc_data,
	// trigger pins
	input  wire logic               external_trigger_input,
	input  wire logic               pps_input,
	// fft core
	output logic                    fft_in_valid,
	output idtc_pkg::idtc_iq_s      fft_in_data,
	input  wire logic               fft_bin_valid,
	input  wire logic [9:0]         fft_bin_idx,
	input  wire logic [31:0]        fft_bin_mag,
	input  wire logic               fft_bin_last,
	// host packets
	output logic                    out_valid,
	output idtc_pkg::idtc_iq_s      out_data,
	output logic                    out_eop,
	input  wire logic               out_ready,
	// sweep engine
	output logic                    sweep_hold
);
	import idtc_pkg::*;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	idtc_trig_e  trig_type;
	idtc_state_e state;
	logic [3:0]  dec_lvl;
	logic [2:0]  rf_mode;
	logic [31:0] shift_inc, lvl_thr, period;
	logic [9:0]  win_start, win_stop;
	logic [15:0] pkts, samples_per_packet;
	logic [7:0]  sync_word;
	logic        sweep_run, stream_on, drop, trig_latched;
	wire w_ctrl = reg_wr && (reg_addr == `IDTC_A_CTRL);
	wire c_blk  = w_ctrl && reg_wdata[`IDTC_C_BLK];
	wire c_str  = w_ctrl && reg_wdata[`IDTC_C_STR];
	wire c_stop = w_ctrl && reg_wdata[`IDTC_C_STOP];
	wire c_read = w_ctrl && reg_wdata[`IDTC_C_READ];
	wire [3:0] dec_wr = (reg_wdata > 32'(`IDTC_DEC_MAX)) ? `IDTC_DEC_MAX : reg_wdata[3:0];
	// [RQ12] trace config apart
	// only these root settings steer a trace; sweep entries live elsewhere
	always_ff @(posedge clk_sys)
		if (srst)
		begin
			trig_type <= TRIG_NONE;
			dec_lvl   <= '0;
			rf_mode   <= '0;
			shift_inc <= '0;
			win_start <= '0;
			win_stop  <= '0;
			lvl_thr   <= '0;
			period    <= '0;
			pkts      <= 16'h0001;
			samples_per_packet       <= 16'h0001;
			sync_word <= '0;
			sweep_run <= 1'b0;
		end
		else if (reg_wr)
		begin
			// [RQ4] reject multi-type writes
			if (reg_addr == `IDTC_A_TRIG && $onehot(reg_wdata[5:0]))
				trig_type <= idtc_trig_e'(reg_wdata[5:0]);
			// [RQ20] level clamped at ten
			if (reg_addr == `IDTC_A_DEC)
				dec_lvl <= dec_wr;
			if (reg_addr == `IDTC_A_MODE)
				rf_mode <= reg_wdata[2:0];
			if (reg_addr == `IDTC_A_SHIFT)
				shift_inc <= reg_wdata;
			if (reg_addr == `IDTC_A_WIN)
			begin
				win_start <= reg_wdata[9:0];
				win_stop  <= reg_wdata[`IDTC_W_STOP +: 10];
			end
			if (reg_addr == `IDTC_A_THR)
				lvl_thr <= reg_wdata;
			if (reg_addr == `IDTC_A_PER)
				period <= reg_wdata;
			if (reg_addr == `IDTC_A_PKTS)
				pkts <= reg_wdata[15:0];
			if (reg_addr == `IDTC_A_SPP)
				samples_per_packet <= reg_wdata[15:0];
			if (reg_addr == `IDTC_A_SWORD)
				sync_word <= reg_wdata[7:0];
			if (reg_addr == `IDTC_A_SWEEP)
				sweep_run <= reg_wdata[0];
		end
	// [RQ6] bin width in 1/16 Hz
	wire [31:0] bin_width = `IDTC_BINW_BASE >> dec_lvl;
	// [RQ16] block length, clamped to memory
	wire [31:0] blk_prod = 32'(pkts) * 32'(samples_per_packet);
	wire [12:0] blk_len = (blk_prod > 32'(`IDTC_MEM_N)) ? `IDTC_MEM_N : blk_prod[12:0];
	logic [31:0] next_rdata;
	always_comb
	begin
		next_rdata = '0;
		if (!reg_rd)
			next_rdata = '0;
		else if (reg_addr == `IDTC_A_TRIG)
			next_rdata = 32'(trig_type);
		else if (reg_addr == `IDTC_A_DEC)
			next_rdata = 32'(dec_lvl);
		else if (reg_addr == `IDTC_A_MODE)
			next_rdata = 32'(rf_mode);
		else if (reg_addr == `IDTC_A_SHIFT)
			next_rdata = shift_inc;
		else if (reg_addr == `IDTC_A_WIN)
			next_rdata = {6'h00, win_stop, 6'h00, win_start};
		else if (reg_addr == `IDTC_A_THR)
			next_rdata = lvl_thr;
		else if (reg_addr == `IDTC_A_PER)
			next_rdata = period;
		else if (reg_addr == `IDTC_A_PKTS)
			next_rdata = 32'(pkts);
		else if (reg_addr == `IDTC_A_SPP)
			next_rdata = 32'(samples_per_packet);
		else if (reg_addr == `IDTC_A_SWORD)
			next_rdata = 32'(sync_word);
		else if (reg_addr == `IDTC_A_STAT)
			next_rdata = {9'h000, drop, trig_latched, state, 3'h0, blk_len};
		else if (reg_addr == `IDTC_A_BINW)
			next_rdata = bin_width;
		else if (reg_addr == `IDTC_A_SWEEP)
			next_rdata = 32'(sweep_run);
	end
	always_ff @(posedge clk_sys)
		reg_rdata <= srst ? '0 : next_rdata;
	// ----------------------------------------
	// oscillator and mixer
	// ----------------------------------------
	function automatic logic signed [7:0] sin_lut(input logic [3:0] k);
		case (k)
			4'h0: sin_lut = 8'sh00;
			4'h1: sin_lut = 8'sh31;
			4'h2: sin_lut = 8'sh5A;
			4'h3: sin_lut = 8'sh75;
			4'h4: sin_lut = 8'sh7F;
			4'h5: sin_lut = 8'sh75;
			4'h6: sin_lut = 8'sh5A;
			4'h7: sin_lut = 8'sh31;
			4'h8: sin_lut = 8'sh00;
			4'h9: sin_lut = 8'shCF;
			4'hA: sin_lut = 8'shA6;
			4'hB: sin_lut = 8'sh8B;
			4'hC: sin_lut = 8'sh81;
			4'hD: sin_lut = 8'sh8B;
			4'hE: sin_lut = 8'shA6;
			default: sin_lut = 8'shCF;
		endcase
	endfunction : sin_lut
	logic [31:0] phase;
	// [RQ21] auto zero-IF shift
	wire sh_mode = (rf_mode == 3'h2) || (rf_mode == 3'h3);
	wire [31:0] inc_eff = shift_inc + ((sh_mode && dec_lvl != 4'h0) ? `IDTC_SH_IF_INC : 32'h0);
	// [RQ3] real-only paths, q zero
	wire real_only = (rf_mode != 3'h0);
	wire signed [15:0] x_i = adc_data.i;
	wire signed [15:0] x_q = real_only ? 16'sh0000 : adc_data.q;
	// [RQ23] cosine is sine a quarter on
	wire signed [7:0] cos_v = sin_lut(phase[31:28] + 4'h4);
	wire signed [7:0] sin_v = sin_lut(phase[31:28]);
	// [RQ1] multiply by conjugate tone
	wire signed [24:0] mix_i = 25'(x_i) * 25'(cos_v) + 25'(x_q) * 25'(sin_v);
	wire signed [24:0] mix_q = 25'(x_q) * 25'(cos_v) - 25'(x_i) * 25'(sin_v);
	logic signed [15:0] m_s [2];
	logic m_v;
	always_ff @(posedge clk_sys)
		if (srst)
		begin
			phase  <= '0;
			m_v    <= 1'b0;
			m_s[0] <= '0;
			m_s[1] <= '0;
		end
		else
		begin
			m_v <= adc_valid;
			if (adc_valid)
			begin
				phase  <= phase + inc_eff;
				m_s[0] <= mix_i[22:7];
				m_s[1] <= mix_q[22:7];
			end
		end
	// ----------------------------------------
	// decimating filters
	// ----------------------------------------
	logic [10:0] dcnt;
	wire [10:0] dec_n_m1 = (11'h001 << dec_lvl) - 11'h001;
	// at or past the end, so a smaller level never strands the counter
	wire tick = m_v && (dcnt >= dec_n_m1);
	wire use_cic = rf_mode[`IDTC_M_CIC];
	logic signed [15:0] y_s [2];
	logic ddc_v;
	always_ff @(posedge clk_sys)
		if (srst)
		begin
			dcnt  <= '0;
			ddc_v <= 1'b0;
		end
		else
		begin
			ddc_v <= tick;
			if (m_v)
				dcnt <= tick ? 11'h000 : dcnt + 11'h001;
		end
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_lane
			logic signed [15:0] h0, h1, h2, k0, k1;
			logic signed [26:0] acc;
			wire signed [17:0] fsum = 18'(m_s[g]) + 18'(h0) + 18'(h1) + 18'(h2);
			wire signed [26:0] asum = acc + 27'(m_s[g]);
			wire signed [26:0] amean = asum >>> dec_lvl;
			wire signed [15:0] cn = amean[15:0];
			// cic droop made up by a small peaking tap set
			wire signed [18:0] cdif = (19'(k0) <<< 1) - 19'(cn) - 19'(k1);
			wire signed [18:0] cmp = 19'(k0) + (cdif >>> 3);
			always_ff @(posedge clk_sys)
				if (srst)
				begin
					{h0, h1, h2, k0, k1} <= '0;
					acc    <= '0;
					y_s[g] <= '0;
				end
				else
				begin
					if (m_v)
						{h2, h1, h0} <= {h1, h0, m_s[g]};
					// [RQ2] filter output select; FIR and CIC share one decimation tick
					if (tick)
					begin
						{k1, k0} <= {k0, cn};
						acc      <= '0;
						y_s[g]   <= use_cic ? cmp[15:0] : fsum[17:2];
					end
					else if (m_v)
						acc <= asum;
				end
		end
	endgenerate
	// [RQ5] decimated samples feed fft
	always_ff @(posedge clk_sys)
		fft_in_valid <= srst ? 1'b0 : tick;
	assign fft_in_data = '{i: y_s[0], q: y_s[1]};
	// ----------------------------------------
	// triggers
	// ----------------------------------------
	logic frame_hit, lvl_evt;
	// [RQ7] bins inside start..stop
	wire in_win = (fft_bin_idx >= win_start) && (fft_bin_idx <= win_stop);
	wire bin_over = in_win && (fft_bin_mag > lvl_thr);
	// [RQ8] any bin over threshold
	// [RQ22] decided at frame end
	always_ff @(posedge clk_sys)
		if (srst)
		begin
			frame_hit <= 1'b0;
			lvl_evt   <= 1'b0;
		end
		else
		begin
			lvl_evt <= fft_bin_valid && fft_bin_last && (frame_hit || bin_over);
			if (fft_bin_valid)
				frame_hit <= fft_bin_last ? 1'b0 : (frame_hit || bin_over);
		end
	logic [31:0] pcnt;
	logic per_evt;
	wire [31:0] per_m1 = (period == 32'h0) ? 32'h0 : period - 32'h1;
	// [RQ10] periodic tick
	always_ff @(posedge clk_sys)
		if (srst || trig_type != TRIG_PERIODIC)
		begin
			pcnt    <= '0;
			per_evt <= 1'b0;
		end
		else
		begin
			per_evt <= (pcnt == per_m1);
			pcnt    <= (pcnt == per_m1) ? 32'h0 : pcnt + 32'h1;
		end
	// pins: three flops; a level counts once stages two and three agree
	logic [2:0] t_s, p_s;
	logic t_f, t_d, p_f, p_d, match_d;
	logic [7:0] t_sh;
	always_ff @(posedge clk_sys)
		if (srst)
		begin
			{t_s, p_s}            <= '0;
			{t_f, t_d, p_f, p_d} <= '0;
			match_d               <= 1'b1;
			t_sh                  <= '0;
		end
		else
		begin
			t_s <= {t_s[1:0], external_trigger_input};
			p_s <= {p_s[1:0], pps_input};
			if (t_s[1] == t_s[2])
				t_f <= t_s[2];
			if (p_s[1] == p_s[2])
				p_f <= p_s[2];
			t_d     <= t_f;
			p_d     <= p_f;
			t_sh    <= {t_sh[6:0], t_f};
			match_d <= (t_sh == sync_word);
		end
	// [RQ11] pulse, pps and sync-word events
	wire pulse_evt = t_f && !t_d;
	wire pps_evt = p_f && !p_d;
	wire word_evt = (t_sh == sync_word) && !match_d;
	wire sel_evt = (trig_type == TRIG_LEVEL && lvl_evt) ||
		(trig_type == TRIG_PERIODIC && per_evt) || (trig_type == TRIG_PPS && pps_evt) ||
		(trig_type == TRIG_PULSE && pulse_evt) || (trig_type == TRIG_WORD && word_evt);
	// ----------------------------------------
	// capture controller
	// ----------------------------------------
	idtc_iq_s mem [1 << `IDTC_MEM_AW];
	logic [12:0] wcnt, rcnt;
	logic [15:0] scnt;
	// [RQ15] none means free run
	wire go = (trig_type == TRIG_NONE) || trig_latched;
	wire out_free = !out_valid || out_ready;
	wire last_w = ddc_v && (wcnt + 13'h1 >= blk_len);
	wire eop_now = (scnt + 16'h1 >= samples_per_packet);
	always_ff @(posedge clk_sys)
		if (srst)
		begin
			state        <= ST_IDLE;
			stream_on    <= 1'b0;
			trig_latched <= 1'b0;
			wcnt         <= '0;
		end
		else
		begin
			// [RQ22] latch holds one capture
			if (state == ST_ARM)
				trig_latched <= go ? 1'b0 : (trig_latched || sel_evt);
			else
				trig_latched <= 1'b0;
			case (state)
				ST_IDLE, ST_HOLD:
				begin
					// [RQ18] stream start arms
					if (c_blk || c_str)
					begin
						state     <= ST_ARM;
						stream_on <= c_str;
					end
					// [RQ17] read command on held block
					else if (state == ST_HOLD && c_read)
						state <= ST_READ;
				end
				ST_ARM:
					if (go)
					begin
						state <= ST_CAP;
						wcnt  <= '0;
					end
				// [RQ9] post-trigger samples to memory
				ST_CAP:
					if (ddc_v)
					begin
						wcnt <= last_w ? 13'h0 : wcnt + 13'h1;
						// [RQ13] full block then hold
						if (last_w && !stream_on)
							state <= ST_HOLD;
						else if (last_w && trig_type != TRIG_NONE)
							state <= ST_ARM;
					end
				ST_READ:
					if (rcnt >= blk_len && out_free)
						state <= ST_HOLD;
				default:
					state <= ST_IDLE;
			endcase
			// [RQ18] stop halts streaming
			if (c_stop && stream_on)
			begin
				state     <= ST_IDLE;
				stream_on <= 1'b0;
			end
		end
	always_ff @(posedge clk_sys)
		if (state == ST_CAP && ddc_v && !stream_on)
			mem[wcnt[`IDTC_MEM_AW-1:0]] <= fft_in_data;
	wire str_push = state == ST_CAP && stream_on && ddc_v;
	wire rd_push = state == ST_READ && out_free && rcnt < blk_len;
	always_ff @(posedge clk_sys)
		if (srst)
		begin
			out_valid <= 1'b0;
			out_data  <= '0;
			out_eop   <= 1'b0;
			rcnt      <= '0;
			scnt      <= '0;
			drop      <= 1'b0;
		end
		else
		begin
			if (c_read || c_str)
			begin
				rcnt <= '0;
				scnt <= '0;
			end
			if (c_str)
				drop <= 1'b0;
			// [RQ14] no room means sample dropped
			if (str_push && !out_free)
				drop <= 1'b1;
			if (str_push && out_free)
			begin
				out_valid <= 1'b1;
				out_data  <= fft_in_data;
				out_eop   <= eop_now;
				scnt      <= eop_now ? 16'h0 : scnt + 16'h1;
			end
			else if (rd_push)
			begin
				out_valid <= 1'b1;
				out_data  <= mem[rcnt[`IDTC_MEM_AW-1:0]];
				out_eop   <= eop_now;
				scnt      <= eop_now ? 16'h0 : scnt + 16'h1;
				rcnt      <= rcnt + 13'h1;
			end
			else if (out_ready)
				out_valid <= 1'b0;
		end
	// [RQ19] trace pauses sweep
	always_ff @(posedge clk_sys)
		sweep_hold <= srst ? 1'b0 : sweep_run && (state != ST_IDLE) && (state != ST_HOLD);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	a_trig_onehot: assert property ($onehot(trig_type)) // [RQ4]
		else $error("trigger type not one-hot");
	a_free_run: assert property (state == ST_ARM && trig_type == TRIG_NONE && !c_stop // [RQ15]
		|=> state == ST_CAP)
		else $error("free run did not start");
	a_wait_trig: assert property (state == ST_ARM && trig_type != TRIG_NONE // [RQ22]
		&& !trig_latched |=> state != ST_CAP)
		else $error("capture without trigger");
	a_lvl_frame: assert property (lvl_evt |-> $past(fft_bin_valid && fft_bin_last)) // [RQ8]
		else $error("level trigger off frame end");
	a_dec_max: assert property (dec_lvl <= `IDTC_DEC_MAX) // [RQ20]
		else $error("decimation above ten");
	a_sh_shift: assert property (sh_mode && dec_lvl != 4'h0 && adc_valid // [RQ21]
		|=> phase == $past(phase) + $past(shift_inc) + `IDTC_SH_IF_INC)
		else $error("zero-IF shift missing");
	a_blk_hold: assert property (state == ST_CAP && !stream_on && last_w && !c_stop // [RQ13]
		|=> state == ST_HOLD ##1 state != ST_CAP)
		else $error("block did not hold");
	a_stop_idle: assert property (c_stop && stream_on // [RQ18]
		|=> state == ST_IDLE && !stream_on)
		else $error("stop did not halt");
	a_read_go: assert property (state == ST_HOLD && c_read && !c_blk && !c_str // [RQ17]
		|=> state == ST_READ)
		else $error("read not started");
	a_drop_flag: assert property (str_push && !out_free |=> drop) // [RQ14]
		else $error("drop not flagged");
	a_sweep_hold: assert property (state == ST_CAP // [RQ19]
		|=> sweep_hold == $past(sweep_run))
		else $error("sweep not paused");
	c_level: cover property (trig_type == TRIG_LEVEL && lvl_evt ##[1:20] state == ST_CAP);
	c_block: cover property (state == ST_READ ##[1:200] state == ST_HOLD);
	c_stream: cover property (stream_on && out_valid && out_ready && out_eop);
	c_drop: cover property (str_push && !out_free);
endmodule : idtc_top

// [tb/idtc_host_model.sv]
/*
 * Host side of the packet port: takes samples, counts them and packet ends.
 * Assumes the block's clock and synchronous reset.
 */
`timescale 1ns/1ps
module idtc_host_model (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               srst,
	// packet port
	input  wire logic               out_valid,
	input  wire idtc_pkg::idtc_iq_s out_data,
	input  wire logic               out_eop,
	output logic                    out_ready,
	// bench control
	input  wire logic               stall,
	input  wire logic               slow,
	output int                      n_samp,
	output int                      n_eop,
	output idtc_pkg::idtc_iq_s      last_data
);
	import idtc_pkg::*;
	logic phase;
	// ----------------------------------------
	// acceptance
	// ----------------------------------------
	// host pulls the block
	// slow mode halves the rate so held outputs get tested
	always @(posedge clk_sys)
	begin
		phase     <= srst ? 1'b0 : ~phase;
		out_ready <= !srst && !stall && !(slow && phase);
	end
	// counts show gaps and packet ends
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			n_samp <= 0;
			n_eop  <= 0;
		end
		else if (out_valid && out_ready)
		begin
			n_samp    <= n_samp + 1;
			n_eop     <= n_eop + int'(out_eop);
			last_data <= out_data;
		end
	end
endmodule : idtc_host_model

// [tb/tb_top.sv]
/*
 * Self-checking bench of the down converter, trigger and capture block.
 * Assumes rtl/ on the include path and the host model beside it.
 */
`timescale 1ns/1ps
`include "idtc_params.svh"
module tb_top;
	import idtc_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clk_sys   = 1'b0;
	logic        srst      = 1'b1;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        adc_valid = 1'b0;
	idtc_iq_s    adc_data  = 32'h0100_0000;
	logic        trig_pin  = 1'b0;
	logic        pps_pin   = 1'b0;
	logic        bin_valid = 1'b0;
	logic [9:0]  bin_idx   = 10'h0;
	logic [31:0] bin_mag   = 32'h0;
	logic        bin_last  = 1'b0;
	logic        stall     = 1'b0;
	logic        slow      = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] rv;
	logic        fft_in_valid;
	logic        out_valid;
	logic        out_eop;
	logic        out_ready;
	logic        sweep_hold;
	idtc_iq_s    fft_in_data;
	idtc_iq_s    out_data;
	idtc_iq_s    last_data;
	int          n_samp;
	int          n_eop;
	int          n0;
	int          e0;
	int          fft_n     = 0;
	int          q_nz      = 0;
	int          bad_count = 0;
	int          tests_run = 0;

	always #10 clk_sys = ~clk_sys;
	// one sample every other cycle
	always @(posedge clk_sys)
		adc_valid <= ~adc_valid;
	always @(posedge clk_sys)
	begin
		fft_n <= fft_n + int'(fft_in_valid);
		q_nz  <= q_nz + int'(fft_in_valid && fft_in_data.q != 16'h0000);
	end

	idtc_top i_idtc_top (
		.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
		.adc_data(adc_data), .external_trigger_input(trig_pin), .pps_input(pps_pin),
		.fft_in_valid(fft_in_valid), .fft_in_data(fft_in_data), .fft_bin_valid(bin_valid),
		.fft_bin_idx(bin_idx), .fft_bin_mag(bin_mag), .fft_bin_last(bin_last),
		.out_valid(out_valid), .out_data(out_data), .out_eop(out_eop),
		.out_ready(out_ready), .sweep_hold(sweep_hold)
	);
	idtc_host_model i_idtc_host_model (
		.clk_sys(clk_sys), .srst(srst), .out_valid(out_valid), .out_data(out_data),
		.out_eop(out_eop), .out_ready(out_ready), .stall(stall), .slow(slow),
		.n_samp(n_samp), .n_eop(n_eop), .last_data(last_data)
	);
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	// bounded poll of the state field; running out ends the run
	task automatic wait_state(input logic [4:0] code, input int bound);
		int k;
		k = 0;
		rd(`IDTC_A_STAT, rv);
		while (rv[20:16] !== code && k < bound)
		begin
			rd(`IDTC_A_STAT, rv);
			k++;
		end
		check(rv[20:16], code);
		if (rv[20:16] !== code)
			complete_run();
	endtask : wait_state
	task automatic frame(input int hot, input logic [31:0] mag);
		for (int b = 0; b < 1024; b++)
		begin
			@(posedge clk_sys);
			bin_valid <= 1'b1;
			bin_idx   <= b[9:0];
			bin_mag   <= (b == hot) ? mag : 32'h0000_0000;
			bin_last  <= (b == 1023);
		end
		@(posedge clk_sys);
		bin_valid <= 1'b0;
		bin_last  <= 1'b0;
	endtask : frame
	// long enough to pass the three-flop pin filter
	task automatic pulse(input logic use_pps);
		@(posedge clk_sys);
		pps_pin  <= use_pps;
		trig_pin <= !use_pps;
		repeat (6) @(posedge clk_sys);
		pps_pin  <= 1'b0;
		trig_pin <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask : pulse
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		rd(`IDTC_A_TRIG, rv);
		check(rv, 32'h01);
		rd(`IDTC_A_STAT, rv);
		check(rv, 32'h0001_0001);
		rd(8'h3C, rv);
		check(rv, 32'h0);
		$display("test reset done");
		for (int t = 0; t < 6; t++)
		begin
			wr(`IDTC_A_TRIG, 32'h1 << t);
			rd(`IDTC_A_TRIG, rv);
			check(rv, 32'h1 << t);
		end
		wr(`IDTC_A_TRIG, 32'h03);
		rd(`IDTC_A_TRIG, rv);
		check(rv, 32'h20);
		for (int d = 0; d < 12; d++)
		begin
			wr(`IDTC_A_DEC, d);
			rd(`IDTC_A_DEC, rv);
			check(rv, (d > 10) ? 32'hA : d);
			rd(`IDTC_A_BINW, rv);
			check(rv, 32'd1953125 >> ((d > 10) ? 10 : d));
		end
		wr(`IDTC_A_PKTS, 32'h2);
		wr(`IDTC_A_SPP, 32'h2);
		rd(`IDTC_A_STAT, rv);
		check(rv[12:0], 32'h4);
		$display("test registers done");
		// decimation two to the level on every path and filter
		for (int m = 0; m < 8; m++)
		begin
			wr(`IDTC_A_MODE, m);
			wr(`IDTC_A_DEC, 32'h2);
			repeat (20) @(posedge clk_sys);
			n0 = fft_n;
			repeat (128) @(posedge clk_sys);
			check(fft_n - n0 >= 15 && fft_n - n0 <= 17, 1);
		end
		wr(`IDTC_A_MODE, 32'h1);
		wr(`IDTC_A_DEC, 32'h0);
		wr(`IDTC_A_SHIFT, 32'h1000_0000);
		e0 = q_nz;
		repeat (64) @(posedge clk_sys);
		check(q_nz > e0, 1);
		$display("test converter done");
		// second reset: clears settings and puts the oscillator phase back at zero
		srst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		rd(`IDTC_A_PKTS, rv);
		check(rv, 32'h1);
		wr(`IDTC_A_PKTS, 32'h2);
		wr(`IDTC_A_SPP, 32'h2);
		wr(`IDTC_A_SWEEP, 32'h1);
		repeat (40) @(posedge clk_sys);
		wr(`IDTC_A_CTRL, 32'h1);
		repeat (2) @(posedge clk_sys);
		check(sweep_hold, 1);
		wait_state(5'h08, 50);
		check(sweep_hold, 0);
		slow <= 1'b1;
		for (int r = 0; r < 2; r++)
		begin
			n0 = n_samp;
			e0 = n_eop;
			wr(`IDTC_A_CTRL, 32'h8);
			wait_state(5'h08, 50);
			check(n_samp - n0, 4);
			check(n_eop - e0, 2);
			// 0x0100 * 127 taken at bits 22:7, no shift, settled mean
			check(last_data, 32'h00FE_0000);
		end
		slow <= 1'b0;
		$display("test block done");
		wr(`IDTC_A_WIN, 32'h0014_000A);
		wr(`IDTC_A_THR, 32'd100);
		wr(`IDTC_A_TRIG, 32'h02);
		wr(`IDTC_A_CTRL, 32'h1);
		wait_state(5'h02, 20);
		frame(5, 32'd200);
		frame(15, 32'd100);
		rd(`IDTC_A_STAT, rv);
		check(rv[20:16], 5'h02);
		frame(15, 32'd101);
		wait_state(5'h08, 50);
		$display("test level done");
		// six filtered ones after zeros make the word 0x3F once
		wr(`IDTC_A_SWORD, 32'h3F);
		for (int k = 0; k < 3; k++)
		begin
			wr(`IDTC_A_TRIG, 32'h08 << k);
			wr(`IDTC_A_CTRL, 32'h1);
			wait_state(5'h02, 20);
			pulse(k != 0);
			rd(`IDTC_A_STAT, rv);
			check(rv[20:16], 5'h02);
			pulse(k == 0);
			wait_state(5'h08, 50);
		end
		wr(`IDTC_A_TRIG, 32'h04);
		wr(`IDTC_A_PER, 32'd40);
		for (int k = 0; k < 2; k++)
		begin
			wr(`IDTC_A_CTRL, 32'h1);
			wait_state(5'h08, 100);
		end
		$display("test pin and periodic done");
		wr(`IDTC_A_TRIG, 32'h01);
		n0 = n_samp;
		wr(`IDTC_A_CTRL, 32'h2);
		repeat (40) @(posedge clk_sys);
		check(n_samp > n0, 1);
		rd(`IDTC_A_STAT, rv);
		check(rv[22], 0);
		stall <= 1'b1;
		repeat (40) @(posedge clk_sys);
		rd(`IDTC_A_STAT, rv);
		check(rv[22], 1);
		stall <= 1'b0;
		wr(`IDTC_A_CTRL, 32'h4);
		wait_state(5'h01, 20);
		repeat (20) @(posedge clk_sys);
		check(out_valid, 0);
		$display("test stream done");
		complete_run();
	end
endmodule : tb_top
